// ===== include/storage_ref_address_gen_cfg.svh
`ifndef STORAGE_REF_ADDRESS_GEN_CFG_SVH
`define STORAGE_REF_ADDRESS_GEN_CFG_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_INSTR 12'h004
`define OFS_PTR 12'h008
`define OFS_ACCQ 12'h00c
`define OFS_STATUS 12'h010
`define OFS_EADDR 12'h014
`define OFS_NEXTP 12'h018

// Control register fields
`define CTRL_START_BIT 0
`define CTRL_MULTI_BIT 1

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_OPND_BIT 2
`define STAT_REGREF_BIT 3

// Fixed location of the second index word
`define INDEX2_ADDR 16'h00ff

// Instruction word fields
`define OPC_MSB 15
`define OPC_LSB 12
`define REL_BIT 11
`define IND_BIT 10
`define X1_BIT 9
`define X2_BIT 8
`define DELTA_MSB 7

`endif

// ===== include/storage_ref_address_gen_pkg.sv
package storage_ref_address_gen_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXT = 3'b001,
        ST_IND = 3'b010,
        ST_IDX2 = 3'b011
    } ag_state_t;

    // Memory read request towards main memory
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } mem_req_t;

    typedef struct packed {
        ag_state_t st;
        mem_req_t mem;
        logic [15:0] instr;
        logic [15:0] ptr;
        logic [15:0] accq;
        logic multi;
        logic [15:0] acc;
        logic [15:0] eaddr;
        logic [15:0] nextp;
        logic busy;
        logic done;
        logic opnd;
        logic regref;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ag_regs_t;

endpackage

// ===== rtl/storage_ref_address_gen.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "storage_ref_address_gen_cfg.svh"

// Summary of operation
// (RULE_01) Instruction is 16 bits, bit 15 MSB
// (RULE_02) Split into opcode, mode flags, delta
// (RULE_03) Index one is Q, two word 00FF
// (RULE_04) Add Q first, then the 00FF word
// (RULE_05) Index only after indirection completes
// (RULE_06) Indexing uses one's complement 16-bit add
// (RULE_07) No index flags: effective equals base
// (RULE_08) Absolute: base is unsigned delta
// (RULE_09) Constant: P+1, or word there plus index
// (RULE_10) Constant mode effective address is operand
// (RULE_11) Indirect: unsigned delta addresses pointer word
// (RULE_12) Storage: word at P+1 is pointer
// (RULE_13) Relative: P plus sign-extended delta
// (RULE_14) 16-bit relative: P+1 plus word there
// (RULE_15) Relative indirect: P+delta addresses pointer word
// (RULE_16) Multilevel: chain while bit 15 set
// (RULE_17) Single level: all 16 bits are base
// (RULE_18) Zero delta C-F: P+1+word locates pointer
// (RULE_19) Next address P+1, or P+2 with extension
// (RULE_20) Upper nibble zero means register reference
// (RULE_21) Fields: opcode 15:12, flags 11:8, delta 7:0
// (RULE_22) Each memory read waits for its data
module storage_ref_address_gen
    import storage_ref_address_gen_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Main memory read port
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Result
    output logic [15:0] eff_addr,
    output logic [15:0] next_addr,
    output logic done
);

    ag_regs_t s_r;
    ag_regs_t s_nxt;

    // End-around carry gives one's complement sum; -0 results pass as computed
    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        oc_add = sum[15:0] + {15'h0000, sum[16]};
    endfunction

    // Decoded fields of the held instruction
    logic [3:0] opc;
    logic rel_f;
    logic ind_f;
    logic x1_f;
    logic x2_f;
    logic [7:0] delta;
    logic [15:0] delta_sx;
    logic [15:0] p_plus1;
    logic [15:0] p_rel;
    logic wr_acc;
    logic rd_setup;

    // Field split of the instruction word
    assign opc = s_r.instr[`OPC_MSB:`OPC_LSB]; // RULE_21
    assign rel_f = s_r.instr[`REL_BIT]; // RULE_02
    assign ind_f = s_r.instr[`IND_BIT];
    assign x1_f = s_r.instr[`X1_BIT];
    assign x2_f = s_r.instr[`X2_BIT];
    assign delta = s_r.instr[`DELTA_MSB:0];
    assign delta_sx = {{8{delta[`DELTA_MSB]}}, delta}; // RULE_13
    assign p_plus1 = s_r.ptr + 16'h0001;
    assign p_rel = s_r.ptr + delta_sx;

    // Bus phases
    assign wr_acc = psel & penable & pwrite & s_r.pready;
    assign rd_setup = psel & ~penable & ~s_r.pready;

    // Sequence map of the address former
    //
    // ST_IDLE
    //   Waits for a start with busy set
    //   Decodes the held word once per start
    //   Upper nibble zero: register reference, no address
    //   Register reference: next is P+1, done at once
    //   Zero delta: second word always consumed
    //   Zero delta: next is P+2 in every mode
    //   Nonzero delta: next is P+1 in every mode
    //   Mode 0, zero delta: P+1 is the result
    //   Mode 0, zero delta: no memory read at all
    //   Other zero-delta modes: read P+1 first
    //   Nonzero delta, no indirect flag: base known now
    //   Nonzero delta, indirect flag: pointer read first
    //
    // ST_EXT
    //   Second word at P+1 is in flight
    //   Request and address stand until acknowledge
    //   Modes 0-3: fetched word plus index values
    //   Modes 0-3: result flagged as the operand
    //   Modes 4-7: fetched word is a pointer
    //   Modes 8-B: P+1 plus fetched word is base
    //   Modes C-F: P+1 plus fetched word is a pointer
    //   Pointer modes go on to ST_IND
    //   Direct modes go on to ST_IDX2
    //
    // ST_IND
    //   Pointer word is in flight
    //   Multilevel with bit 15 set: read again
    //   Chained read keeps the request raised
    //   Chained read changes only the address
    //   Single level: all 16 bits become base
    //   Base formed: index one may now apply
    //   Index one never touches a mid-chain pointer
    //
    // ST_IDX2
    //   No index two: base plus index one is result
    //   Index two: fixed word read on every use
    //   Fixed word is never kept between starts
    //   Software may change it between instructions
    //   Result, done and idle busy land together
    //
    // Per mode, nonzero delta
    //   0: delta as unsigned base
    //   1: delta plus fixed word
    //   2: delta plus index one
    //   3: delta plus index one, then fixed word
    //   4: word at delta
    //   5: word at delta plus fixed word
    //   6: word at delta plus index one
    //   7: word at delta plus both indexes
    //   8: P plus signed delta
    //   9: P plus signed delta plus fixed word
    //   A: P plus signed delta plus index one
    //   B: P plus signed delta plus both indexes
    //   C: word at P plus signed delta
    //   D: that word plus fixed word
    //   E: that word plus index one
    //   F: that word plus both indexes
    //
    // Per mode, zero delta
    //   0: P+1 itself, taken as operand
    //   1: word at P+1 plus fixed word
    //   2: word at P+1 plus index one
    //   3: word at P+1 plus both indexes
    //   4: word addressed by word at P+1
    //   5: as 4, plus fixed word
    //   6: as 4, plus index one
    //   7: as 4, plus both indexes
    //   8: P+1 plus word at P+1
    //   9: as 8, plus fixed word
    //   A: as 8, plus index one
    //   B: as 8, plus both indexes
    //   C: word addressed by P+1 plus word at P+1
    //   D: as C, plus fixed word
    //   E: as C, plus index one
    //   F: as C, plus both indexes
    //
    // Arithmetic
    //   Pointer sums wrap as plain binary
    //   Index sums use end-around carry
    //   Index values carry their sign in bit 15
    //   Minus zero results are not folded
    //   Folding would cost an extra adder stage
    //
    // Memory port
    //   One read at a time, never overlapped
    //   Address stands until the read is acknowledged
    //   Acknowledge without request is ignored
    //   Data is only looked at with acknowledge
    //   Zero-wait memory answers the next cycle
    //   Slow memory simply stretches each state
    //
    // Limitations
    //   A pointer loop in multilevel mode never ends
    //   Only a reset breaks such a loop
    //   Operand registers freeze while busy
    //   Writes while busy still get a ready
    //   Start while busy is dropped silently
    //
    // Timing
    //   No-read modes: done two edges after start, one for zero-delta mode 0 and register reference
    //   Each read adds its latency plus one edge
    //   Index two adds one read and no further edge
    //   Done stays high until the next start
    //   Result registers hold until then as well
    //
    // Bus side
    //   Ready always follows setup by one cycle
    //   Read data stands only in the access cycle
    //   Unmapped offsets answer with an error
    //   Control start bit reads back as zero
    //   Status is read-only; writes are ignored

    always_comb begin
        s_nxt = s_r;
        // Ready is pulsed one cycle after setup, so every access has one wait-free access cycle
        s_nxt.pready = rd_setup;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0000_0000;
        if (rd_setup) begin
            case (paddr)
                `OFS_CTRL: s_nxt.prdata = {30'h0, s_r.multi, 1'b0};
                `OFS_INSTR: s_nxt.prdata = {16'h0000, s_r.instr};
                `OFS_PTR: s_nxt.prdata = {16'h0000, s_r.ptr};
                `OFS_ACCQ: s_nxt.prdata = {16'h0000, s_r.accq};
                `OFS_STATUS: s_nxt.prdata = {28'h0, s_r.regref, s_r.opnd, s_r.done, s_r.busy};
                `OFS_EADDR: s_nxt.prdata = {16'h0000, s_r.eaddr};
                `OFS_NEXTP: s_nxt.prdata = {16'h0000, s_r.nextp};
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        // Writes land at the completing edge; operands are frozen while busy
        if (wr_acc && !s_r.busy) begin
            case (paddr)
                `OFS_INSTR: s_nxt.instr = pwdata[15:0]; // RULE_01
                `OFS_PTR: s_nxt.ptr = pwdata[15:0];
                `OFS_ACCQ: s_nxt.accq = pwdata[15:0];
                default: ;
            endcase
        end
        if (wr_acc && !s_r.busy && paddr == `OFS_CTRL) begin
            s_nxt.multi = pwdata[`CTRL_MULTI_BIT];
            if (pwdata[`CTRL_START_BIT]) begin
                s_nxt.busy = 1'b1;
                s_nxt.done = 1'b0;
                s_nxt.opnd = 1'b0;
                s_nxt.regref = 1'b0;
                s_nxt.st = ST_IDLE;
            end
        end

        // Address formation sequence
        case (s_r.st)
            ST_IDLE: begin
                if (s_r.busy && !s_r.done) begin
                    if (opc == 4'h0) begin
                        // Not a storage reference; no address is formed
                        s_nxt.regref = 1'b1; // RULE_20
                        s_nxt.nextp = p_plus1;
                        s_nxt.done = 1'b1;
                        s_nxt.busy = 1'b0;
                    end else if (delta == 8'h00) begin
                        // Second word needed for every zero-delta mode
                        s_nxt.nextp = s_r.ptr + 16'h0002; // RULE_19
                        if (!rel_f && !ind_f && !x1_f && !x2_f) begin
                            s_nxt.eaddr = p_plus1; // RULE_09
                            s_nxt.opnd = 1'b1; // RULE_10
                            s_nxt.done = 1'b1;
                            s_nxt.busy = 1'b0;
                        end else begin
                            s_nxt.mem.req = 1'b1;
                            s_nxt.mem.addr = p_plus1;
                            s_nxt.st = ST_EXT;
                        end
                    end else begin
                        s_nxt.nextp = p_plus1; // RULE_19
                        case ({rel_f, ind_f})
                            2'b00: s_nxt.acc = {8'h00, delta}; // RULE_08
                            2'b01: s_nxt.mem.addr = {8'h00, delta}; // RULE_11
                            2'b10: s_nxt.acc = p_rel; // RULE_13
                            default: s_nxt.mem.addr = p_rel; // RULE_15
                        endcase
                        if (ind_f) begin
                            s_nxt.mem.req = 1'b1;
                            s_nxt.st = ST_IND;
                        end else begin
                            s_nxt.acc = {rel_f ? p_rel : {8'h00, delta}};
                            s_nxt.st = ST_IDX2;
                            // Apply index one now; index two is handled in ST_IDX2
                            if (x1_f) begin
                                s_nxt.acc = oc_add(rel_f ? p_rel : {8'h00, delta}, s_r.accq); // RULE_04
                            end
                        end
                    end
                end
            end
            ST_EXT: begin
                // Hold request until memory answers
                if (mem_ack) begin // RULE_22
                    s_nxt.mem.req = 1'b0;
                    case ({rel_f, ind_f})
                        2'b00: begin
                            s_nxt.opnd = 1'b1; // RULE_10
                            s_nxt.acc = x1_f ? oc_add(mem_rdata, s_r.accq) : mem_rdata; // RULE_09
                            s_nxt.st = ST_IDX2;
                        end
                        2'b01: begin
                            s_nxt.mem.req = 1'b1;
                            s_nxt.mem.addr = mem_rdata; // RULE_12
                            s_nxt.st = ST_IND;
                        end
                        2'b10: begin
                            s_nxt.acc = x1_f ? oc_add(p_plus1 + mem_rdata, s_r.accq)
                                             : p_plus1 + mem_rdata; // RULE_14
                            s_nxt.st = ST_IDX2;
                        end
                        default: begin
                            s_nxt.mem.req = 1'b1;
                            s_nxt.mem.addr = p_plus1 + mem_rdata; // RULE_18
                            s_nxt.st = ST_IND;
                        end
                    endcase
                end
            end
            ST_IND: begin
                if (mem_ack) begin // RULE_22
                    if (s_r.multi && mem_rdata[15]) begin
                        // Chain: another pointer, fetched as a separate read
                        s_nxt.mem.addr = mem_rdata; // RULE_16
                    end else begin
                        s_nxt.mem.req = 1'b0;
                        // Base formed; index one applies only now
                        s_nxt.acc = x1_f ? oc_add(mem_rdata, s_r.accq) : mem_rdata; // RULE_05 RULE_17
                        s_nxt.st = ST_IDX2;
                    end
                end
            end
            ST_IDX2: begin
                if (!x2_f) begin
                    s_nxt.eaddr = s_r.acc; // RULE_07
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = ST_IDLE;
                end else if (!s_r.mem.req) begin
                    // Fixed word is fetched on every use, never cached
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.addr = `INDEX2_ADDR; // RULE_03
                end else if (mem_ack) begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.eaddr = oc_add(s_r.acc, mem_rdata); // RULE_04 RULE_06
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
                s_nxt.mem.req = 1'b0;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    // Whole state in one register bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign mem_req = s_r.mem.req;
    assign mem_addr = s_r.mem.addr;
    assign eff_addr = s_r.eaddr;
    assign next_addr = s_r.nextp;
    assign done = s_r.done;

endmodule

// ===== dv/storage_ref_address_gen_asserts.sv
`timescale 1ns/100ps
module storage_ref_address_gen_asserts(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Memory and result
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] eff_addr,
    input wire logic done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers after exactly one access cycle
    setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    // Each read stands until answered
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped early");
    done_quiet_a: assert property (done |-> !mem_req) else $error("read while done");
    result_hold_a: assert property (done && !psel |=> done && $stable(eff_addr))
        else $error("result moved while idle");
endmodule
bind storage_ref_address_gen storage_ref_address_gen_asserts storage_ref_address_gen_asserts_i(.pclk, .presetn,
    .psel, .penable, .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_ack, .eff_addr, .done);

// ===== dv/mem_model.sv
`timescale 1ns/100ps
module mem_model(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Read port
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:65535];
    int lat = 0;
    int cnt;
    // Answer after lat waits; data line scrambles outside answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0;
            cnt <= 0;
        end else if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= 0;
        end else if (cnt >= lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
        end else begin
            cnt <= cnt + 1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ===== dv/storage_ref_address_gen_test.sv
`timescale 1ns/100ps
`include "storage_ref_address_gen_cfg.svh"
module storage_ref_address_gen_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mem_req, mem_ack, done, err;
    logic [15:0] mem_addr, mem_rdata, eff_addr, next_addr;
    int err_count = 0, n_compared = 0;

    // Block and its memory
    storage_ref_address_gen storage_ref_address_gen_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .eff_addr, .next_addr, .done);
    mem_model mem_model_i(.pclk, .presetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

    initial forever #25 pclk = ~pclk;

    task chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // One transfer; an idle edge after it so psel never toggles twice at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // End-around carry add
    function logic [15:0] oc(input logic [15:0] a, b);
        logic [16:0] s;
        s = a + b;
        return s[15:0] + s[16];
    endfunction

    task run(input logic [15:0] ins, p, q, input logic ml, input logic [15:0] ea, na, input logic [3:0] st);
        apb(1, `OFS_PTR, p);
        apb(1, `OFS_ACCQ, q);
        apb(1, `OFS_INSTR, ins);
        apb(1, `OFS_CTRL, {30'h0, ml, 1'b1});
        repeat (300) if (done !== 1'b1) @(posedge pclk);
        if (!st[3]) chk("eff_addr", eff_addr, ea);
        chk("next_addr", next_addr, na);
        apb(0, `OFS_STATUS, 0);
        chk("status", rd[3:0], st);
    endtask

    task t_bus;
        apb(0, 12'hffc, 0);
        chk("slverr", err, 1'b1);
        chk("unmapped data", rd, 0);
    endtask
    task t_abs;
        mem_model_i.mem[16'h00ff] = 16'h0007;
        run(16'h1320, 16'h0100, 16'h0005, 0, 16'h002c, 16'h0101, 4'h2);
        run(16'h10f0, 16'h0100, 16'h0005, 0, 16'h00f0, 16'h0101, 4'h2);
    endtask
    task t_const;
        mem_model_i.mem[16'h0101] = 16'h0040;
        run(16'h1000, 16'h0100, 16'h0000, 0, 16'h0101, 16'h0102, 4'h6);
        run(16'h1200, 16'h0100, 16'hfffd, 0, oc(16'h0040, 16'hfffd), 16'h0102, 4'h6);
    endtask
    task t_ind;
        mem_model_i.lat = 3;
        mem_model_i.mem[16'h0030] = 16'h1234;
        mem_model_i.mem[16'h0031] = 16'h9000;
        run(16'h1430, 16'h0100, 16'h0000, 0, 16'h1234, 16'h0101, 4'h2);
        run(16'h1431, 16'h0100, 16'h0000, 0, 16'h9000, 16'h0101, 4'h2);
        mem_model_i.lat = 0;
    endtask
    task t_multi;
        mem_model_i.mem[16'h00fe] = 16'h8040;
        mem_model_i.mem[16'h8040] = 16'h0123;
        mem_model_i.mem[16'h0040] = 16'h0456;
        run(16'h1dfe, 16'h0100, 16'h0000, 1, 16'h012a, 16'h0101, 4'h2);
    endtask
    task t_rel;
        mem_model_i.mem[16'h0201] = 16'h0010;
        run(16'h1880, 16'h0200, 16'h0000, 0, 16'h0180, 16'h0201, 4'h2);
        run(16'h1a00, 16'h0200, 16'hfffe, 0, 16'h0210, 16'h0202, 4'h2);
    endtask
    task t_store;
        mem_model_i.mem[16'h0301] = 16'h0050;
        mem_model_i.mem[16'h0050] = 16'h0300;
        mem_model_i.mem[16'h0401] = 16'h0020;
        mem_model_i.mem[16'h0421] = 16'h0555;
        run(16'h1700, 16'h0300, 16'h0001, 0, 16'h0308, 16'h0302, 4'h2);
        run(16'h1c00, 16'h0400, 16'h0000, 0, 16'h0555, 16'h0402, 4'h2);
        run(16'h0123, 16'h0500, 16'h0000, 0, 16'h0000, 16'h0501, 4'ha);
    endtask

    task conclude;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard well past the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_bus();
        t_abs();
        t_const();
        t_ind();
        t_multi();
        t_rel();
        t_store();
        conclude();
    end
endmodule
